// File: interrupt_level_fields.sv
// Holds the priority level fields of sources 16 and 1 and the request they form.
// Assumes write strobe, data and pending inputs synchronous to core_clk.
`timescale 1ns/100ps
// How it works
// - Bits 18 to 16 of the word hold a writable three-bit level for source 16, the PCI controller interrupt.
// - Bits 10 to 8 of the word hold a writable three-bit level for source 1, the write-timeout error.
// - A source whose level is zero is disabled and its request never reaches the processor.
// - Levels one to seven are the priority value itself, with seven the highest.
// - Reset clears the source 16 level to zero.
// - Reset clears the source 1 level to zero.
module interrupt_level_fields
   import level_pkg::*;
(
   // Clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      srst,
   // Field access
   input  wire logic                      wr_en,
   input  wire logic [level_pkg::WORD_W-1:0] wr_data,
   output logic      [level_pkg::WORD_W-1:0] rd_data,
   // Sources
   input  wire logic                      pci_controller_interrupt,
   input  wire logic                      wr_timeout_err,
   // Request to processor
   output level_pkg::level_t              req_level,
   output logic [1:0]                     req_src,
   output logic                           req_valid
);
   import level_pkg::*;

   // Level fields, one per source
   level_t            src16_r;
   level_t            src16_nxt;
   level_t            src1_r;
   level_t            src1_nxt;
   // Readback word
   logic [WORD_W-1:0] rd_r;
   logic [WORD_W-1:0] rd_nxt;
   // Registered request
   level_t            req_level_r;
   level_t            req_level_nxt;
   logic [1:0]        req_src_r;
   logic [1:0]        req_src_nxt;
   logic              req_valid_r;
   logic              req_valid_nxt;
   // Resolver result, combinational
   level_t            win_level;
   logic [1:0]        win_src;

   // Carrier towards the resolver leaf
   level_if lv ();

   // Pull one level field out of a written word; lo is the field's low bit
   // Bits outside the field are simply not looked at, so reserved bits are ignored
   function automatic level_t field_of(input logic [WORD_W-1:0] word, input int lo);
      return word[lo +: LVL_W];
   endfunction : field_of

   // Readback word: both fields in place, every reserved bit zero
   // Built from scratch each time so no stale reserved bit can leak out
   function automatic logic [WORD_W-1:0] pack_word(input level_t l16, input level_t l1);
      logic [WORD_W-1:0] w;
      w                    = '0;
      w[SRC16_HI:SRC16_LO] = l16;
      w[SRC1_HI:SRC1_LO]   = l1;
      return w;
   endfunction : pack_word

   // Current levels and pending inputs go to the resolver every cycle
   // Pending inputs are levels, so no edge detection is needed here
   assign lv.src16_level = src16_r;
   assign lv.src1_level  = src1_r;
   assign lv.src16_pend  = pci_controller_interrupt;
   assign lv.src1_pend   = wr_timeout_err;

   // Priority pick between the two sources
   level_resolve u_resolve (
      .lv        (lv.user),
      .win_level (win_level),
      .win_src   (win_src)
   );

   // Field group: one write loads both levels from one word
   // Reset clears them and wins over a write in the same cycle
   always_comb begin
      src16_nxt = src16_r;
      src1_nxt  = src1_r;
      if (srst) begin
         src16_nxt = LVL_RESET;
         src1_nxt  = LVL_RESET;
      end else if (wr_en) begin
         src16_nxt = field_of(wr_data, SRC16_LO);
         src1_nxt  = field_of(wr_data, SRC1_LO);
      end
   end

   always_ff @(posedge core_clk) begin
      src16_r <= src16_nxt;
      src1_r  <= src1_nxt;
   end

   // Readback group: follows the next field values,
   // so a write shows on the same edge that loads the fields
   always_comb begin
      rd_nxt = pack_word(src16_nxt, src1_nxt);
      if (srst) begin
         rd_nxt = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      rd_r <= rd_nxt;
   end

   // Request group: the resolver result is registered so the outputs come from flops
   // A write taken at one edge therefore reaches the request one edge later
   // Reset clears the request on the same edge as the fields
   always_comb begin
      req_level_nxt = win_level;
      req_src_nxt   = win_src;
      req_valid_nxt = (win_level != LVL_DISABLED);
      if (srst) begin
         req_level_nxt = LVL_DISABLED;
         req_src_nxt   = 2'h0;
         req_valid_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      req_level_r <= req_level_nxt;
      req_src_r   <= req_src_nxt;
      req_valid_r <= req_valid_nxt;
   end

   // Outputs straight from the registers
   assign rd_data   = rd_r;
   assign req_level = req_level_r;
   assign req_src   = req_src_r;
   assign req_valid = req_valid_r;

   // Checks below are clocked on core_clk and muted while srst is high,
   // except the reset checks, which watch the edge after reset, and every cover but COV_TIE

   // Writes land on both fields together and nothing else moves them
   AST_WR16: assert property (@(posedge core_clk) disable iff (srst)
      wr_en |=> src16_r == $past(wr_data[SRC16_HI:SRC16_LO]))
      else $error("src16 write lost");

   AST_WR1: assert property (@(posedge core_clk) disable iff (srst)
      wr_en |=> src1_r == $past(wr_data[SRC1_HI:SRC1_LO]))
      else $error("src1 write lost");

   AST_HOLD: assert property (@(posedge core_clk) disable iff (srst)
      !wr_en |=> $stable(src16_r) && $stable(src1_r))
      else $error("field changed without write");

   // Readback mirrors the fields and keeps reserved bits at zero
   AST_RDBK: assert property (@(posedge core_clk) disable iff (srst)
      rd_r[SRC16_HI:SRC16_LO] == src16_r && rd_r[SRC1_HI:SRC1_LO] == src1_r)
      else $error("readback differs from fields");

   AST_RSVD: assert property (@(posedge core_clk) disable iff (srst)
      (rd_r & ~FIELD_MASK) == '0)
      else $error("reserved bits nonzero");

   // Disabled sources never request, and an idle request shows no level or source
   AST_DIS16: assert property (@(posedge core_clk) disable iff (srst)
      (src16_r == 3'h0 && !(wr_timeout_err && src1_r != 3'h0)) |=> !req_valid_r)
      else $error("disabled src16 requested");

   AST_DIS1: assert property (@(posedge core_clk) disable iff (srst)
      (src1_r == 3'h0 && !pci_controller_interrupt) |=> !req_valid_r)
      else $error("disabled src1 requested");

   AST_IDLE: assert property (@(posedge core_clk) disable iff (srst)
      !req_valid_r |-> req_level_r == 3'h0 && req_src_r == 2'h0)
      else $error("idle request carries a level");

   AST_VLD: assert property (@(posedge core_clk) disable iff (srst)
      req_valid_r |-> req_level_r != 3'h0 && req_src_r != 2'h0)
      else $error("request without level");

   AST_SRC: assert property (@(posedge core_clk) disable iff (srst)
      req_src_r != 2'h3)
      else $error("illegal source code");

   // The higher level wins; equal levels go to source 16
   AST_PRIO: assert property (@(posedge core_clk) disable iff (srst)
      (pci_controller_interrupt && src16_r != 3'h0) |=> req_valid_r && req_level_r >= $past(src16_r))
      else $error("level not granted");

   AST_PRIO1: assert property (@(posedge core_clk) disable iff (srst)
      (wr_timeout_err && src1_r != 3'h0) |=> req_valid_r && req_level_r >= $past(src1_r))
      else $error("src1 level not granted");

   AST_WIN16: assert property (@(posedge core_clk) disable iff (srst)
      (pci_controller_interrupt && src16_r != 3'h0 && !(wr_timeout_err && src1_r > src16_r))
      |=> req_src_r == 2'h2 && req_level_r == $past(src16_r))
      else $error("src16 should win");

   AST_WIN1: assert property (@(posedge core_clk) disable iff (srst)
      (wr_timeout_err && src1_r != 3'h0 && !(pci_controller_interrupt && src16_r >= src1_r))
      |=> req_src_r == 2'h1 && req_level_r == $past(src1_r))
      else $error("src1 should win");

   // Reset clears both fields, the readback and the request
   AST_RST: assert property (@(posedge core_clk)
      srst |=> src16_r == 3'h0 && src1_r == 3'h0 && !req_valid_r)
      else $error("reset values wrong");

   AST_RDRST: assert property (@(posedge core_clk)
      srst |=> rd_r == '0 && req_level_r == 3'h0 && req_src_r == 2'h0)
      else $error("reset readback or request wrong");

   // Main scenarios
   COV_16: cover property (@(posedge core_clk) req_valid_r && req_src_r == 2'h2);
   COV_1: cover property (@(posedge core_clk) req_valid_r && req_src_r == 2'h1);
   COV_MAX: cover property (@(posedge core_clk) req_level_r == 3'h7);
   COV_TIE: cover property (@(posedge core_clk) disable iff (srst)
      pci_controller_interrupt && wr_timeout_err && src16_r != 3'h0 && src16_r == src1_r);
   COV_WR_RST: cover property (@(posedge core_clk) srst && wr_en);
endmodule : interrupt_level_fields

// File: level_pkg.sv
// Package: constants for the two interrupt priority level fields.
// Assumes a single core clock domain with synchronous active-high reset.
package level_pkg;
   localparam int           LVL_W          = 3;
   localparam int           SRC16_HI       = 18;
   localparam int           SRC16_LO       = 16;
   localparam int           SRC1_HI        = 10;
   localparam int           SRC1_LO        = 8;
   localparam int           WORD_W         = 32;
   localparam logic [2:0]   LVL_RESET      = 3'h0;
   localparam logic [2:0]   LVL_DISABLED   = 3'h0;
   localparam logic [31:0]  FIELD_MASK     = 32'h0007_0700;
   typedef logic [LVL_W-1:0] level_t;
endpackage : level_pkg

// File: level_if.sv
// Interface: level fields and pending gating carried to the resolver stage.
// Assumes the owner drives levels from flops each cycle.
`timescale 1ns/100ps
interface level_if;
   import level_pkg::*;
   level_t src16_level;
   level_t src1_level;
   logic   src16_pend;
   logic   src1_pend;
   modport owner (output src16_level, output src1_level, output src16_pend, output src1_pend);
   modport user  (input src16_level, input src1_level, input src16_pend, input src1_pend);
endinterface : level_if

// File: level_resolve.sv
// Resolver leaf: picks the effective request level of the two sources.
// Assumes levels and pending bits come from the owner over level_if.
`timescale 1ns/100ps
module level_resolve
   import level_pkg::*;
(
   // Field side
   level_if.user      lv,
   // Result
   output level_t     win_level,
   output logic [1:0] win_src
);
   // A source counts only while pending and enabled; a zero level never requests
   function automatic level_t eff_level(input logic pend, input level_t lvl);
      return (pend && lvl != LVL_DISABLED) ? lvl : LVL_DISABLED;
   endfunction : eff_level

   // Disabled (zero) sources never request; higher binary value wins
   always_comb begin
      level_t l16;
      level_t l1;
      l16 = eff_level(lv.src16_pend, lv.src16_level);
      l1  = eff_level(lv.src1_pend, lv.src1_level);
      win_level = LVL_DISABLED;
      win_src   = 2'h0;
      if (l16 != LVL_DISABLED && l16 >= l1) begin
         win_level = l16;
         win_src   = 2'h2;
      end else if (l1 != LVL_DISABLED) begin
         win_level = l1;
         win_src   = 2'h1;
      end
   end
endmodule : level_resolve

// File: interrupt_level_fields_test.sv
// Testbench: table-driven checks of both level fields and the request they form.
// Assumes a lone design instance; inputs change on falling edges only.
`timescale 1ns/100ps
module interrupt_level_fields_test;
   import level_pkg::*;
   typedef struct {logic [31:0] wd; logic p16; logic p1; logic [31:0] rd; level_t lv; logic [1:0] src;} row_t;
   logic        core_clk = 1'b0;
   logic        srst     = 1'b1;
   logic        wr_en    = 1'b0;
   logic [31:0] wr_data  = 32'h0;
   logic        pci      = 1'b0;
   logic        wto      = 1'b0;
   logic [31:0] rd_data;
   level_t      req_level;
   logic [1:0]  req_src;
   logic        req_valid;
   int          fail_count = 0;
   int          n_compared = 0;
   int          cyc        = 0;
   row_t        rows [8]   = '{
      '{32'hffffffff, 1'b1, 1'b1, 32'h00070700, 3'h7, 2'h2},  // Reserved bits dropped, tie
      '{32'h00050300, 1'b1, 1'b1, 32'h00050300, 3'h5, 2'h2},
      '{32'h00020600, 1'b1, 1'b1, 32'h00020600, 3'h6, 2'h1},
      '{32'h00000400, 1'b1, 1'b1, 32'h00000400, 3'h4, 2'h1},  // Source 16 off
      '{32'h00000400, 1'b0, 1'b0, 32'h00000400, 3'h0, 2'h0},
      '{32'h00030000, 1'b0, 1'b1, 32'h00030000, 3'h0, 2'h0},  // Source 1 off
      '{32'h00010000, 1'b1, 1'b0, 32'h00010000, 3'h1, 2'h2},
      '{32'hfff8f8ff, 1'b1, 1'b1, 32'h00000000, 3'h0, 2'h0}}; // Reserved only
   row_t        r;

   interrupt_level_fields u_dut (.core_clk(core_clk), .srst(srst), .wr_en(wr_en), .wr_data(wr_data),
      .rd_data(rd_data), .pci_controller_interrupt(pci), .wr_timeout_err(wto),
      .req_level(req_level), .req_src(req_src), .req_valid(req_valid));

   // Clock and cycle ceiling
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         fail_count++;
         print_verdict();
      end
   end

   // Compare and count
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Write a row, then check readback and the request one edge later
   task automatic run(row_t x);
      @(negedge core_clk);
      wr_en = 1'b1; wr_data = x.wd; pci = x.p16; wto = x.p1;
      @(negedge core_clk);
      wr_en = 1'b0;
      chk("rd_data", rd_data, x.rd);
      @(negedge core_clk);
      chk("req_level", {29'h0, req_level}, {29'h0, x.lv});
      chk("req_src", {30'h0, req_src}, {30'h0, x.src});
      chk("req_valid", {31'h0, req_valid}, {31'h0, x.lv != 3'h0});
   endtask : run

   task automatic print_verdict();
      if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   // Main sequence
   initial begin
      repeat (20) @(negedge core_clk);
      srst = 1'b0;
      chk("rd_data", rd_data, 32'h0);
      foreach (rows[i]) run(rows[i]);
      // Every nonzero level of source 1 alone
      for (int l = 1; l < 8; l++) begin
         r = '{{21'h0, 3'(l), 8'h0}, 1'b0, 1'b1, {21'h0, 3'(l), 8'h0}, 3'(l), 2'h1};
         run(r);
      end
      run(rows[0]);
      // Back-to-back writes: each shows in the readback on the same edge that takes it
      @(negedge core_clk);
      wr_en = 1'b1; wr_data = 32'h00010200;
      @(negedge core_clk);
      chk("rd_data", rd_data, 32'h00010200);
      wr_data = 32'h00040700;
      @(negedge core_clk);
      wr_en = 1'b0;
      chk("rd_data", rd_data, 32'h00040700);
      // Reset wins over a write in the same cycle
      @(negedge core_clk);
      srst = 1'b1; wr_en = 1'b1; wr_data = 32'h00070700;
      @(negedge core_clk);
      srst = 1'b0; wr_en = 1'b0;
      chk("rd_data", rd_data, 32'h0);
      @(negedge core_clk);
      chk("req_valid", {31'h0, req_valid}, 32'h0);
      print_verdict();
   end
endmodule : interrupt_level_fields_test
